// >>> hdl/picture_state_decoder.sv
// Added by the designer: the address map and register access over Wishbone.
`include "picture_state_regs.svh"
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - no matrix flag: flat 4x4, or flat 8x8 instead if transform flag set; drop matrix data
// - matrix flag set: accept matrix data while valid
// - structure 00 frame, 01 top, 11 bottom
// - structure bit 0 alone marks field decoding
// - frame-store index only 0..16, high bits zero
// - index 0..15 picks write base from table
// - index 16 picks top or bottom write base
// - software programs index 16 for sixteen references
// - low seven bits 7F mean non-existing picture
// - index selects current picture order count
// - residual offset in dwords, multiple of eight
// - sync overwrite: flag only available-neighbour non-PCM intra
// - no overwrite: copy root-thread bit through
// - sixteen-vector disabled: map size 16 to 32
// - chroma 00 monochrome, 01 4:2:0 supported
// - deblock write off: write no deblock data
// - deblock write on: write all, default unfiltered
// - entropy bit: 0 variable-length, 1 arithmetic
// - non-reference flag marks picture unused later
// - constrained intra: inter neighbours unavailable
// - direct inference: 8x8 granularity only
// - transform flag allows 8x8 inverse transforms
// - state retained until reset or new command
module picture_state_decoder
    import picture_state_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    state_cmd_if.decoder                 cmd,
    input  wire logic [`ADDR_WIDTH-1:0]  mv_read_base_table_i [32],
    input  wire logic [`ADDR_WIDTH-1:0]  mv_write_base_top_i,
    input  wire logic [`ADDR_WIDTH-1:0]  mv_write_base_bottom_i,
    input  wire logic [31:0]             picture_order_list_i [17],
    input  wire logic                    matrix_data_valid_i,
    input  wire logic                    mb_is_intra_i,
    input  wire logic                    mb_is_pcm_i,
    input  wire logic                    mb_neighbour_avail_i,
    input  wire logic [1:0]              mv_size_i,
    input  wire logic                    slice_deblock_on_i,
    output logic [`ADDR_WIDTH-1:0]       mv_write_base_o,
    output logic [31:0]                  current_poc_o,
    output logic                         matrix_data_accept_o,
    output logic                         use_flat_4x4_o,
    output logic                         use_flat_8x8_o,
    output logic                         field_decode_o,
    output logic                         bottom_field_o,
    output logic                         monochrome_o,
    output logic                         arith_decode_o,
    output logic                         non_reference_picture_o,
    output logic                         constrained_intra_o,
    output logic                         direct_inference_8x8_o,
    output logic                         transform_8x8_allowed_o,
    output logic [7:0]                   residual_offset_o,
    output logic                         thread_sync_o,
    output logic [1:0]                   mv_size_o,
    output logic                         deblock_write_o,
    output logic                         deblock_no_filter_o,
    output logic                         picture_loaded_o,
    output logic                         bad_state_o
);
    typedef struct packed {
        logic [3:0]              dword_count;
        logic                    header_ok;
        logic [31:0]             dw3_hold;
        logic [31:0]             dw4_hold;
        picture_fields_type      fields;
        logic                    loaded;
        logic                    bad;
        logic [`ADDR_WIDTH-1:0]  mv_base;
        logic [31:0]             poc;
        logic                    mat_accept;
        logic                    thread_sync;
        logic [1:0]              mv_size;
        logic                    deblock_write;
        logic                    deblock_no_filter;
        logic                    flat_4x4;
        logic                    flat_8x8;
        logic                    field_decode;
        logic                    bottom_field;
        logic                    monochrome;
    } state_type;

    state_type r;
    state_type next_r;
    picture_fields_type f;
    logic [4:0] idx;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_r = r;
        f = r.fields;
        if (cmd.valid) begin
            next_r.dword_count = r.dword_count + 4'd1;
            if (r.dword_count == 4'd0) begin
                // other commands may share the link; only this header arms the latch
                next_r.header_ok = cmd.data == {`IMG_CMD_TYPE, `IMG_CMD_PIPELINE, `IMG_CMD_OPCODE,
                                                `IMG_CMD_SUBOPCODE, `IMG_CMD_LENGTH};
            end
            // dwords 3 and 4 wait for the last beat, so a cut command changes nothing
            if (r.dword_count == 4'd3) begin
                next_r.dw3_hold = cmd.data;
            end
            if (r.dword_count == 4'd4) begin
                next_r.dw4_hold = cmd.data;
            end
            if (cmd.last) begin
                next_r.dword_count = 4'd0;
            end
            // only the named fields are taken; reserved bits reach dw3_hold and dw4_hold but never the fields
            if (cmd.last && r.header_ok) begin
                f.scaling_matrix_present    = r.dw3_hold[`DW3_SCALING_PRESENT];
                f.pic_struct                = pic_struct_type'(r.dw3_hold[`DW3_PIC_STRUCT_HI:`DW3_PIC_STRUCT_LO]);
                f.current_frame_store_index = r.dw3_hold[`DW3_FS_INDEX_HI:`DW3_FS_INDEX_LO];
                f.residual_offset           = r.dw4_hold[`DW4_RESID_HI:`DW4_RESID_LO];
                f.sync_overwrite            = r.dw4_hold[`DW4_SYNC_OVERWRITE];
                f.root_thread_marker        = r.dw4_hold[`DW4_ROOT_THREAD];
                f.sixteen_vector_enable     = r.dw4_hold[`DW4_SIXTEEN_MV];
                f.chroma_sampling_format    = chroma_type'(r.dw4_hold[`DW4_CHROMA_HI:`DW4_CHROMA_LO]);
                f.deblock_data_write_enable = r.dw4_hold[`DW4_DEBLOCK_WRITE];
                f.entropy_arith             = r.dw4_hold[`DW4_ENTROPY];
                f.non_reference_picture     = r.dw4_hold[`DW4_NON_REFERENCE];
                f.constrained_intra         = r.dw4_hold[`DW4_CONSTRAINED_INTRA];
                f.direct_inference_8x8      = r.dw4_hold[`DW4_DIRECT_8X8];
                f.transform_8x8_allowed     = r.dw4_hold[`DW4_TRANSFORM_8X8];
                next_r.fields = f;
                next_r.loaded = 1'b1;
                // flag illegal programming; fields keep the values given, but low five index bits above 16 zero the write base and order count
                next_r.bad = (f.pic_struct == STRUCT_BAD)
                    || (f.current_frame_store_index[6:0] == `FS_NON_EXISTING)
                    || (f.current_frame_store_index[4:0] > `FS_INDEX_WRITE_BASE)
                    || (f.current_frame_store_index[7:5] != 3'h0)
                    || ((f.residual_offset & `RESID_ALIGN_MASK) != 8'h00)
                    || f.chroma_sampling_format[1];
            end
        end

        // write base and order count follow the newly latched index
        idx = f.current_frame_store_index[4:0];
        if (idx == `FS_INDEX_WRITE_BASE) begin
            next_r.mv_base = (f.pic_struct == STRUCT_BOTTOM) ? mv_write_base_bottom_i : mv_write_base_top_i;
            next_r.poc = picture_order_list_i[16];
        end else if (idx < `FS_INDEX_WRITE_BASE) begin
            // table holds a top/bottom pair per frame store
            next_r.mv_base = mv_read_base_table_i[{idx[3:0], f.pic_struct[1]}];
            next_r.poc = picture_order_list_i[idx];
        end else begin
            // illegal index: keep the list read in bounds instead of returning unknowns
            next_r.mv_base = {`ADDR_WIDTH{1'b0}};
            next_r.poc = 32'h0000_0000;
        end

        // per-macroblock controls follow their inputs by one cycle
        next_r.mat_accept = f.scaling_matrix_present && matrix_data_valid_i;
        if (f.sync_overwrite) begin
            next_r.thread_sync = mb_is_intra_i && !mb_is_pcm_i && mb_neighbour_avail_i;
        end else begin
            next_r.thread_sync = f.root_thread_marker;
        end
        next_r.mv_size = (!f.sixteen_vector_enable && mv_size_i == `MV_SIZE_16) ? `MV_SIZE_32 : mv_size_i;
        next_r.deblock_write = f.deblock_data_write_enable;
        next_r.deblock_no_filter = f.deblock_data_write_enable && !slice_deblock_on_i;

        // derived flags are registered so every output except the constant cmd.ready leaves a flip-flop
        next_r.flat_4x4 = !f.scaling_matrix_present && !f.transform_8x8_allowed;
        next_r.flat_8x8 = !f.scaling_matrix_present && f.transform_8x8_allowed;
        next_r.field_decode = f.pic_struct[0];
        next_r.bottom_field = f.pic_struct[1];
        next_r.monochrome = f.chroma_sampling_format == CHROMA_MONO;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // clears loaded: outputs read as unprogrammed until the first command
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // always ready: every field is taken in a single cycle
    assign cmd.ready               = 1'b1;
    assign mv_write_base_o         = r.mv_base;
    assign current_poc_o           = r.poc;
    assign matrix_data_accept_o    = r.mat_accept;
    assign use_flat_4x4_o          = r.flat_4x4;
    assign use_flat_8x8_o          = r.flat_8x8;
    assign field_decode_o          = r.field_decode;
    assign bottom_field_o          = r.bottom_field;
    assign monochrome_o            = r.monochrome;
    assign arith_decode_o          = r.fields.entropy_arith;
    assign non_reference_picture_o = r.fields.non_reference_picture;
    assign constrained_intra_o     = r.fields.constrained_intra;
    assign direct_inference_8x8_o  = r.fields.direct_inference_8x8;
    assign transform_8x8_allowed_o = r.fields.transform_8x8_allowed;
    assign residual_offset_o       = r.fields.residual_offset;
    assign thread_sync_o           = r.thread_sync;
    assign mv_size_o               = r.mv_size;
    assign deblock_write_o         = r.deblock_write;
    assign deblock_no_filter_o     = r.deblock_no_filter;
    assign picture_loaded_o        = r.loaded;
    assign bad_state_o             = r.bad;
endmodule

// >>> shared/picture_state_regs.svh
`ifndef PICTURE_STATE_REGS_SVH
`define PICTURE_STATE_REGS_SVH
// image-state command: eight dwords, length field holds 4, four less than the dword count
`define IMG_CMD_DWORDS        4'd8
`define IMG_CMD_LENGTH        16'h0004
`define IMG_CMD_TYPE          3'h3
`define IMG_CMD_PIPELINE      2'h2
`define IMG_CMD_OPCODE        3'h4
`define IMG_CMD_SUBOPCODE     8'h00
// dword 3 fields
`define DW3_SCALING_PRESENT   10
`define DW3_PIC_STRUCT_HI     9
`define DW3_PIC_STRUCT_LO     8
`define DW3_FS_INDEX_HI       7
`define DW3_FS_INDEX_LO       0
// dword 4 fields
`define DW4_RESID_HI          31
`define DW4_RESID_LO          24
`define DW4_SYNC_OVERWRITE    17
`define DW4_ROOT_THREAD       16
`define DW4_SIXTEEN_MV        12
`define DW4_CHROMA_HI         11
`define DW4_CHROMA_LO         10
`define DW4_DEBLOCK_WRITE     8
`define DW4_ENTROPY           7
`define DW4_NON_REFERENCE     6
`define DW4_CONSTRAINED_INTRA 5
`define DW4_DIRECT_8X8        4
`define DW4_TRANSFORM_8X8     3
// constants
`define FS_INDEX_WRITE_BASE   5'd16
`define FS_NON_EXISTING       7'h7F
`define RESID_ALIGN_MASK      8'h07
`define MV_SIZE_16            2'h1
`define MV_SIZE_32            2'h2
`define ADDR_WIDTH            32
// controller registers (wishbone byte offsets)
`define REG_CTRL              4'h0
`define REG_STATUS            4'h4
`define REG_DW3               4'h8
`define REG_DW4               4'hC
`define CTRL_START            0
`define STATUS_BUSY           0
`define STATUS_DONE           1
`endif

// >>> shared/picture_state_pkg.sv
package picture_state_pkg;
    typedef enum logic [1:0] {
        STRUCT_FRAME  = 2'h0,
        STRUCT_TOP    = 2'h1,
        STRUCT_BAD    = 2'h2,
        STRUCT_BOTTOM = 2'h3
    } pic_struct_type;
    typedef enum logic [1:0] {
        CHROMA_MONO = 2'h0,
        CHROMA_420  = 2'h1,
        CHROMA_422  = 2'h2,
        CHROMA_444  = 2'h3
    } chroma_type;
    typedef struct packed {
        logic           scaling_matrix_present;
        pic_struct_type pic_struct;
        logic [7:0]     current_frame_store_index;
        logic [7:0]     residual_offset;
        logic           sync_overwrite;
        logic           root_thread_marker;
        logic           sixteen_vector_enable;
        chroma_type     chroma_sampling_format;
        logic           deblock_data_write_enable;
        logic           entropy_arith;
        logic           non_reference_picture;
        logic           constrained_intra;
        logic           direct_inference_8x8;
        logic           transform_8x8_allowed;
    } picture_fields_type;
endpackage

// >>> shared/state_cmd_if.sv
interface state_cmd_if;
    logic        valid;
    logic        ready;
    logic [31:0] data;
    logic        last;
    modport streamer (output valid, output data, output last, input ready);
    modport decoder  (input valid, input data, input last, output ready);
endinterface

// >>> hdl/command_streamer.sv
`include "picture_state_regs.svh"
module command_streamer
    import picture_state_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    state_cmd_if.streamer    cmd
);
    typedef enum logic [1:0] {
        IDLE,
        SEND
    } phase_type;

    typedef struct packed {
        phase_type   phase;
        logic [3:0]  count;
        logic [31:0] dw3;
        logic [31:0] dw4;
        logic        done;
        logic        ack;
        logic [31:0] rdata;
        logic        valid;
        logic        last;
        logic [31:0] data;
    } state_type;

    state_type r;
    state_type next_r;
    logic      req;
    logic [31:0] wmask;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_r = r;
        next_r.ack = 1'b0;
        req = cyc_i && stb_i && !r.ack;
        wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
        if (req) begin
            next_r.ack = 1'b1;
            next_r.rdata = 32'h0000_0000;
            unique case (adr_i)
                `REG_CTRL: begin
                    // a start while busy is dropped so a command is never torn
                    if (we_i && sel_i[0] && dat_i[`CTRL_START] && r.phase == IDLE) begin
                        next_r.phase = SEND;
                        next_r.count = 4'd0;
                        next_r.done = 1'b0;
                    end
                end
                `REG_STATUS: next_r.rdata = {30'h0, r.done, r.phase == SEND};
                `REG_DW3: begin
                    if (we_i && r.phase == IDLE) begin
                        next_r.dw3 = (r.dw3 & ~wmask) | (dat_i & wmask);
                    end
                    next_r.rdata = r.dw3;
                end
                `REG_DW4: begin
                    if (we_i && r.phase == IDLE) begin
                        next_r.dw4 = (r.dw4 & ~wmask) | (dat_i & wmask);
                    end
                    next_r.rdata = r.dw4;
                end
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end
        next_r.valid = 1'b0;
        next_r.last = 1'b0;
        if (r.phase == SEND && cmd.ready) begin
            next_r.valid = 1'b1;
            next_r.count = r.count + 4'd1;
            unique case (r.count)
                4'd0: next_r.data = {`IMG_CMD_TYPE, `IMG_CMD_PIPELINE, `IMG_CMD_OPCODE, `IMG_CMD_SUBOPCODE,
                                     `IMG_CMD_LENGTH};
                4'd3: next_r.data = r.dw3;
                4'd4: next_r.data = r.dw4;
                default: next_r.data = 32'h0000_0000;
            endcase
            if (r.count == `IMG_CMD_DWORDS - 4'd1) begin
                next_r.last = 1'b1;
                next_r.phase = IDLE;
                next_r.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
            r.dw3 <= {21'h0, 1'b0, 2'h0, 3'h0, `FS_INDEX_WRITE_BASE};
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign dat_o      = r.rdata;
    assign ack_o      = r.ack;
    assign cmd.valid  = r.valid;
    assign cmd.last   = r.last;
    assign cmd.data   = r.data;
endmodule

// >>> tb/state_cmd_sva.sv
`include "picture_state_regs.svh"
module state_cmd_sva (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        valid,
    input  wire logic        ready,
    input  wire logic [31:0] data,
    input  wire logic        last
);
    timeunit 1ns;
    timeprecision 100ps;
    // beat counter inside one command, so the last flag can be tied to the eighth dword
    logic [3:0] beat;
    logic [3:0] next_beat;
    always_comb begin
        next_beat = beat;
        if (valid) begin
            next_beat = last ? 4'h0 : beat + 4'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            beat <= 4'h0;
        end else begin
            beat <= next_beat;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    property p_ready;
        ready;
    endproperty
    a_ready: assert property (p_ready) else $error("decoder not ready");
    property p_header;
        $rose(valid) |-> data[31:29] == `IMG_CMD_TYPE && data[28:27] == `IMG_CMD_PIPELINE
            && data[26:24] == `IMG_CMD_OPCODE && data[23:16] == `IMG_CMD_SUBOPCODE;
    endproperty
    a_header: assert property (p_header) else $error("bad command header");
    property p_length;
        $rose(valid) |-> data[15:0] == `IMG_CMD_LENGTH;
    endproperty
    a_length: assert property (p_length) else $error("bad dword length");
    property p_burst;
        $rose(valid) |-> valid [*8];
    endproperty
    a_burst: assert property (p_burst) else $error("command shorter than eight dwords");
    property p_last_pos;
        valid |-> (last == (beat == 4'h7));
    endproperty
    a_last_pos: assert property (p_last_pos) else $error("last not on eighth dword");
    property p_gap;
        last |=> !valid;
    endproperty
    a_gap: assert property (p_gap) else $error("valid after last");
    property p_last_valid;
        last |-> valid;
    endproperty
    a_last_valid: assert property (p_last_valid) else $error("last without valid");
    property p_first;
        $rose(valid) |-> beat == 4'h0;
    endproperty
    a_first: assert property (p_first) else $error("command started mid count");
endmodule

// >>> tb/tb_video_decode_picture_state.sv
`include "picture_state_regs.svh"
module tb_video_decode_picture_state;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, top_base, bot_base, mv_base, poc, q;
    logic [31:0] rd_table [32];
    logic [31:0] poc_list [17];
    logic        mdv = 1'b0, intra = 1'b0, pcm = 1'b0, avail = 1'b0, sdb = 1'b0;
    logic [1:0]  mvsz = 2'h2, mvsz_o;
    logic [7:0]  resid;
    logic        accept, flat4, flat8, field, bottom, mono, arith, nonref, cintra, d8, t8, tsync, dbw, nofilt;
    logic        loaded, bad;
    int          errors = 0, n_checks = 0, seed = 32'h6cd8e922;
    always #10 clk_i = ~clk_i;
    state_cmd_if link ();
    command_streamer u_command_streamer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .cmd(link.streamer));
    picture_state_decoder u_picture_state_decoder (.clk_i(clk_i), .rst_i(rst_i), .cmd(link.decoder),
        .mv_read_base_table_i(rd_table), .mv_write_base_top_i(top_base), .mv_write_base_bottom_i(bot_base),
        .picture_order_list_i(poc_list), .matrix_data_valid_i(mdv), .mb_is_intra_i(intra), .mb_is_pcm_i(pcm),
        .mb_neighbour_avail_i(avail), .mv_size_i(mvsz), .slice_deblock_on_i(sdb), .mv_write_base_o(mv_base),
        .current_poc_o(poc), .matrix_data_accept_o(accept), .use_flat_4x4_o(flat4), .use_flat_8x8_o(flat8),
        .field_decode_o(field), .bottom_field_o(bottom), .monochrome_o(mono), .arith_decode_o(arith),
        .non_reference_picture_o(nonref), .constrained_intra_o(cintra), .direct_inference_8x8_o(d8),
        .transform_8x8_allowed_o(t8), .residual_offset_o(resid), .thread_sync_o(tsync), .mv_size_o(mvsz_o),
        .deblock_write_o(dbw), .deblock_no_filter_o(nofilt), .picture_loaded_o(loaded), .bad_state_o(bad));
    state_cmd_sva chk (.clk_i(clk_i), .rst_i(rst_i), .valid(link.valid), .ready(link.ready), .data(link.data),
        .last(link.last));
    ////////////////////////////////////////////////////////////
    task automatic check_bit(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // classic single cycle; no fixed latency assumed, only a bounded wait
    task automatic wb_cycle(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        if (n >= 20) errors++;
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    function automatic logic bad_exp(input logic [31:0] d3, input logic [31:0] d4);
        return d3[9:8] == 2'h2 || d3[7:0] > 8'd16 || d4[26:24] != 3'h0 || d4[11];
    endfunction
    task automatic check_fields(input logic [31:0] d3, input logic [31:0] d4);
        logic [31:0] r;
        logic [7:0]  idx;
        logic [1:0]  st;
        r = $random(seed);
        idx = d3[7:0];
        st = d3[9:8];
        @(posedge clk_i);
        mdv <= r[0];
        intra <= r[1];
        pcm <= r[2];
        avail <= r[3];
        mvsz <= r[4] ? 2'h1 : 2'h2;
        sdb <= r[6];
        repeat (2) @(posedge clk_i);
        check_bit("flat_4x4", !d3[10] && !d4[3], flat4);
        check_bit("flat_8x8", !d3[10] && d4[3], flat8);
        check_bit("matrix_accept", d3[10] && r[0], accept);
        check_bit("field", st[0], field);
        check_bit("bottom", st[1], bottom);
        if (idx < 8'd16) check_word("mv_base", rd_table[{idx[3:0], st[1]}], mv_base);
        if (idx == 8'd16) check_word("mv_base", st == 2'h3 ? bot_base : top_base, mv_base);
        if (idx <= 8'd16) check_word("poc", poc_list[idx[4:0]], poc);
        check_word("resid", {24'h0, d4[31:24]}, {24'h0, resid});
        check_bit("sync", d4[17] ? (r[1] && !r[2] && r[3]) : d4[16], tsync);
        check_word("mv_size", {30'h0, (!d4[12] && r[4]) ? 2'h2 : mvsz}, {30'h0, mvsz_o});
        check_bit("mono", d4[11:10] == 2'h0, mono);
        check_bit("deblock", d4[8], dbw);
        check_bit("no_filter", d4[8] && !r[6], nofilt);
        check_bit("arith", d4[7], arith);
        check_bit("non_ref", d4[6], nonref);
        check_bit("c_intra", d4[5], cintra);
        check_bit("d8", d4[4], d8);
        check_bit("t8", d4[3], t8);
        check_bit("loaded", 1'b1, loaded);
        check_bit("bad", bad_exp(d3, d4), bad);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        print_verdict();
    end
    initial begin
        logic [31:0] d3, d4, p3, p4;
        logic        have;
        int          n;
        for (int i = 0; i < 32; i++) rd_table[i] = $random(seed);
        for (int i = 0; i < 17; i++) poc_list[i] = $random(seed);
        top_base = $random(seed);
        bot_base = $random(seed);
        have = 1'b0;
        for (int t = 0; t < 48; t++) begin
            if (t == 0 || t == 24) begin
                rst_i <= 1'b1;
                repeat (16) @(posedge clk_i);
                rst_i <= 1'b0;
                have = 1'b0;
                wb_cycle(1'b0, `REG_DW3, 32'h0, q);
                check_word("dw3_reset", 32'h10, q);
                wb_cycle(1'b0, 4'h2, 32'h0, q);
                check_word("unmapped", 32'h0, q);
                check_bit("loaded_reset", 1'b0, loaded);
            end
            // reserved bits stay random on purpose: they must not disturb any field
            d3 = $random(seed);
            d4 = $random(seed);
            d3[7:0] = 8'(d3[7:0] % 17);
            d3[9:8] = d3[9] ? 2'h3 : {1'b0, d3[8]};
            d4[26:24] = 3'h0;
            d4[11] = 1'b0;
            case (t)
                1: d3[9:0] = 10'h310;
                2: d3[9:0] = 10'h10F;
                3: d3[9:0] = 10'h000;
                4: d3[9:8] = 2'h2;
                5: d3[7:0] = 8'h7F;
                6: d3[7:0] = 8'h21;
                7: d4[31:24] = 8'h03;
                8: d4[11:10] = 2'h2;
                9: d4[11:10] = 2'h3;
                10: d3[7:0] = 8'h11;
                default: ;
            endcase
            wb_cycle(1'b1, `REG_DW3, d3, q);
            wb_cycle(1'b1, `REG_DW4, d4, q);
            if (have) check_fields(p3, p4);
            wb_cycle(1'b1, `REG_CTRL, 32'h1, q);
            n = 0;
            do begin
                wb_cycle(1'b0, `REG_STATUS, 32'h0, q);
                n++;
            end while (q[1:0] !== 2'b10 && n < 50);
            if (n >= 50) errors++;
            repeat (4) @(posedge clk_i);
            check_fields(d3, d4);
            p3 = d3;
            p4 = d4;
            have = 1'b1;
            $display("test %0d done", t);
        end
        print_verdict();
    end
endmodule
